// *** inc/dsc_alu_defs.svh ***
// constants of the operand select and arithmetic datapath
`ifndef DSC_ALU_DEFS_SVH
`define DSC_ALU_DEFS_SVH
`define NUM_WREGS    16
`define ADDR_W_LAST  5'h0f
`define ADDR_STATUS  5'h10
`define ADDR_ACCA_L  5'h11
`define ADDR_ACCA_H  5'h12
`define ADDR_ACCA_U  5'h13
`define ADDR_ACCB_L  5'h14
`define ADDR_ACCB_H  5'h15
`define ADDR_ACCB_U  5'h16
`define DEFAULT_REG  4'h0
`define REM_REG      4'h1
`define MAC_LO       4'h4
`define MAC_HI       4'h7
`define XP_MAIN      4'h8
`define XP_ALT       4'h9
`define YP_MAIN      4'ha
`define YP_ALT       4'hb
`define PF_OFFSET    4'hc
`define LIT_BYTE_MAX 10'h0ff
`define LIT_WORD_MAX 10'h3ff
`define ACC_POS_MAX  40'h7f_ffff_ffff
`define ACC_NEG_MAX  40'h80_0000_0000
`define STATE_RST    '0
`endif

// *** inc/dsc_alu_pkg.sv ***
// types of the operand select and arithmetic datapath
package dsc_alu_pkg;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_ADD = 4'h1, OP_ADD_WITH_CARRY = 4'h2, OP_AND = 4'h3,
    OP_ASR = 4'h4, OP_ACC_ADD = 4'h5, OP_MPY = 4'h6, OP_SQR = 4'h7,
    OP_DIV = 4'h8
  } op_type;
  typedef enum logic [2:0] {
    FM_FILE = 3'h0, FM_FILE_DEF = 3'h1, FM_MEDIUM_LITERAL = 3'h2,
    FM_REG3 = 3'h3, FM_SHORT_LITERAL = 3'h4, FM_SH_REG = 3'h5, FM_SH_LIT = 3'h6
  } form_type;
  typedef enum logic [3:0] {
    PF_NONE = 4'h0, PF_PLAIN = 4'h1, PF_INC2 = 4'h2, PF_INC4 = 4'h3,
    PF_INC6 = 4'h4, PF_DEC2 = 4'h5, PF_DEC4 = 4'h6, PF_DEC6 = 4'h7,
    PF_INDEX = 4'h8
  } pf_type;
  typedef struct packed {
    logic        valid;
    op_type      op;
    form_type    form;
    logic        byte_mode;
    logic [3:0]  src;
    logic [3:0]  base;
    logic [3:0]  dst;
    logic [9:0]  lit;
    logic        acc_b;
    logic [15:0] file_rdata;
    pf_type      x_mode;
    logic        x_alt;
    logic [1:0]  x_dst;
    logic [15:0] x_rdata;
    pf_type      y_mode;
    logic        y_alt;
    logic [1:0]  y_dst;
    logic [15:0] y_rdata;
  } cmd_type;
  typedef struct packed {
    logic sb, sa, ob, oa, z, ov, n, dc, c;
  } flags_type;
  typedef struct packed {
    logic        ok;
    logic        re;
    logic        alt;
    logic [15:0] addr;
    logic [15:0] ptr;
  } pf_res_type;
  typedef struct packed {
    logic [15:0][15:0] w;
    logic [39:0]       acc_a;
    logic [39:0]       acc_b;
    flags_type         fl;
    logic [15:0]       rdata;
    logic [15:0]       file_wdata;
    logic              file_we;
    logic [15:0]       x_addr;
    logic              x_re;
    logic [15:0]       y_addr;
    logic              y_re;
    logic              err;
  } state_type;
endpackage

// *** rtl/dsc_alu.sv ***
// operand select, register file and arithmetic datapath of the core
`timescale 1ns/1ns
`include "dsc_alu_defs.svh"
module dsc_alu
  import dsc_alu_pkg::*;
#(
  parameter int NUM_REGS = 16
) (
  input  wire logic        I_CLOCK,
  input  wire logic        I_RSTN,
  input  wire cmd_type     I_CMD,
  input  wire logic [4:0]  I_ADDR,
  input  wire logic [15:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [15:0] O_RDATA,
  output logic      [15:0] O_FILE_WDATA,
  output logic             O_FILE_WE,
  output logic      [15:0] O_X_ADDR,
  output logic             O_X_RE,
  output logic      [15:0] O_Y_ADDR,
  output logic             O_Y_RE,
  output flags_type        O_FLAGS,
  output logic             O_ERROR
);

  if (NUM_REGS != `NUM_WREGS) begin : g_chk
    $error("only a sixteen entry register file is supported");
  end

  state_type st_reg;
  state_type st_next;

  function automatic logic is_mac(input logic [3:0] idx);
    is_mac = (idx >= `MAC_LO) && (idx <= `MAC_HI);
  endfunction

  // returns {carry, half carry, range exceed, sum}
  function automatic logic [18:0] add16(input logic [15:0] a,
                                        input logic [15:0] b,
                                        input logic        ci);
    logic [16:0] s;
    logic [4:0]  h;
    s = {1'b0, a} + {1'b0, b} + {16'h0000, ci};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    add16 = {s[16], h[4], (a[15] == b[15]) && (s[15] != a[15]),
             s[15:0]};
  endfunction

  // one prefetch channel: pointer pick, address, post adjust
  function automatic pf_res_type prefetch(input pf_type      m,
                                          input logic        alt,
                                          input logic [15:0] pa,
                                          input logic [15:0] pb,
                                          input logic [15:0] ofs);
    pf_res_type r;
    logic [15:0] p;
    p = alt ? pb : pa;
    r = '{ok: 1'b1, re: (m != PF_NONE), alt: alt, addr: p, ptr: p};
    unique case (m)
      PF_NONE, PF_PLAIN: r.ptr = p;
      PF_INC2: r.ptr = p + 16'h0002;
      PF_INC4: r.ptr = p + 16'h0004;
      PF_INC6: r.ptr = p + 16'h0006;
      PF_DEC2: r.ptr = p - 16'h0002;
      PF_DEC4: r.ptr = p - 16'h0004;
      PF_DEC6: r.ptr = p - 16'h0006;
      PF_INDEX: begin
        // indexed fetch only through the alternate pointer
        r.ok   = alt;
        r.addr = p + ofs;
      end
      default: r.ok = 1'b0;
    endcase
    prefetch = r;
  endfunction

  always_comb begin
    state_type   keep;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] res;
    logic [18:0] s;
    logic        ok;
    logic        to_file;
    logic [3:0]  di;
    logic [39:0] av;
    logic [39:0] acc;
    logic [40:0] wide;
    logic [3:0]  mag;
    logic [31:0] prod;
    logic        rng;
    logic        sat;
    pf_res_type  px;
    pf_res_type  py;
    keep = st_reg;
    keep.file_we = 1'b0;
    keep.x_re = 1'b0;
    keep.y_re = 1'b0;
    keep.err = 1'b0;
    keep.rdata = 16'h0000;
    st_next = keep;
    a = 16'h0000;
    b = 16'h0000;
    res = 16'h0000;
    s = 19'h00000;
    ok = 1'b1;
    to_file = 1'b0;
    di = I_CMD.dst;
    av = 40'h00_0000_0000;
    acc = I_CMD.acc_b ? st_reg.acc_b : st_reg.acc_a;
    wide = 41'h000_0000_0000;
    mag = 4'h0;
    prod = 32'h0000_0000;
    rng = 1'b0;
    sat = 1'b0;
    px = prefetch(I_CMD.x_mode, I_CMD.x_alt, st_reg.w[`XP_MAIN],
                  st_reg.w[`XP_ALT], st_reg.w[`PF_OFFSET]);
    py = prefetch(I_CMD.y_mode, I_CMD.y_alt, st_reg.w[`YP_MAIN],
                  st_reg.w[`YP_ALT], st_reg.w[`PF_OFFSET]);
    // operand selection shared by add, carry add, and, shift
    unique case (I_CMD.form)
      FM_FILE: begin
        a = I_CMD.file_rdata;
        b = st_reg.w[`DEFAULT_REG];
        to_file = 1'b1;
      end
      FM_FILE_DEF: begin
        a = I_CMD.file_rdata;
        b = st_reg.w[`DEFAULT_REG];
        di = `DEFAULT_REG;
      end
      FM_MEDIUM_LITERAL: begin
        a = st_reg.w[I_CMD.dst];
        b = {6'h00, I_CMD.lit};
        ok = I_CMD.lit <= (I_CMD.byte_mode ? `LIT_BYTE_MAX
                                           : `LIT_WORD_MAX);
      end
      FM_REG3: begin
        a = st_reg.w[I_CMD.base];
        b = st_reg.w[I_CMD.src];
      end
      FM_SHORT_LITERAL, FM_SH_LIT: begin
        a = st_reg.w[I_CMD.base];
        b = {11'h000, I_CMD.lit[4:0]};
      end
      FM_SH_REG: begin
        a = st_reg.w[I_CMD.base];
        b = st_reg.w[I_CMD.src];
      end
      default: ok = 1'b0;
    endcase
    if (I_CMD.valid) begin
      unique case (I_CMD.op)
        OP_NOP: ok = 1'b1;
        OP_ADD, OP_ADD_WITH_CARRY: begin
          // carry enters only the carry add
          s = add16(a, b, (I_CMD.op == OP_ADD_WITH_CARRY) && st_reg.fl.c);
          res = s[15:0];
          st_next.fl.c = s[18];
          st_next.fl.dc = s[17];
          st_next.fl.ov = s[16];
          st_next.fl.n = res[15];
          // carry add zero is sticky so chained adds test whole width
          st_next.fl.z = (I_CMD.op == OP_ADD_WITH_CARRY) ?
                         (st_reg.fl.z && (res == 16'h0000)) :
                         (res == 16'h0000);
          ok = ok && (I_CMD.form <= FM_SHORT_LITERAL);
        end
        OP_AND: begin
          res = a & b;
          st_next.fl.n = res[15];
          st_next.fl.z = (res == 16'h0000);
          ok = ok && (I_CMD.form <= FM_SHORT_LITERAL);
        end
        OP_ASR: begin
          if (I_CMD.form >= FM_SH_REG) begin
            // count wider than 15 still fills with the sign
            res = 16'($signed(a) >>> b[4:0]);
          end else begin
            if (I_CMD.form == FM_REG3) begin
              a = st_reg.w[I_CMD.src];
            end
            res = {a[15], a[15:1]};
            st_next.fl.c = a[0];
            st_next.fl.ov = 1'b0;
          end
          st_next.fl.n = res[15];
          st_next.fl.z = (res == 16'h0000);
          ok = ok && (I_CMD.form != FM_MEDIUM_LITERAL) && (I_CMD.form != FM_SHORT_LITERAL);
        end
        OP_ACC_ADD: begin
          av = {{8{st_reg.w[I_CMD.src][15]}}, st_reg.w[I_CMD.src],
                16'h0000};
          mag = 4'(-I_CMD.lit[3:0]);
          av = I_CMD.lit[3] ? (av << mag)
                            : 40'($signed(av) >>> I_CMD.lit[3:0]);
          wide = {acc[39], acc} + {av[39], av};
          sat = wide[40] != wide[39];
          acc = sat ? (wide[40] ? `ACC_NEG_MAX : `ACC_POS_MAX)
                    : wide[39:0];
          rng = !((&acc[39:31]) || !(|acc[39:31]));
          if (I_CMD.acc_b) begin
            st_next.acc_b = acc;
            st_next.fl.ob = rng;
            st_next.fl.sb = st_reg.fl.sb || sat;
          end else begin
            st_next.acc_a = acc;
            st_next.fl.oa = rng;
            st_next.fl.sa = st_reg.fl.sa || sat;
          end
        end
        OP_MPY, OP_SQR: begin
          if (I_CMD.op == OP_SQR) begin
            ok = is_mac(I_CMD.src);
            a = st_reg.w[I_CMD.src];
            b = a;
          end else begin
            ok = is_mac(I_CMD.base) && is_mac(I_CMD.src) &&
                 (I_CMD.base < I_CMD.src);
            a = st_reg.w[I_CMD.base];
            b = st_reg.w[I_CMD.src];
          end
          prod = 32'($signed(a) * $signed(b));
          acc = {{8{prod[31]}}, prod};
          if (I_CMD.acc_b) begin
            st_next.acc_b = acc;
          end else begin
            st_next.acc_a = acc;
          end
          ok = ok && px.ok && py.ok;
          if (px.re) begin
            st_next.w[px.alt ? `XP_ALT : `XP_MAIN] = px.ptr;
            st_next.w[{2'b01, I_CMD.x_dst}] = I_CMD.x_rdata;
          end
          if (py.re) begin
            st_next.w[py.alt ? `YP_ALT : `YP_MAIN] = py.ptr;
            st_next.w[{2'b01, I_CMD.y_dst}] = I_CMD.y_rdata;
          end
          st_next.x_re = px.re;
          st_next.x_addr = px.re ? px.addr : st_reg.x_addr;
          st_next.y_re = py.re;
          st_next.y_addr = py.re ? py.addr : st_reg.y_addr;
        end
        OP_DIV: begin
          // register numbers only, so no pointer mode can reach here
          a = st_reg.w[I_CMD.base];
          b = st_reg.w[I_CMD.src];
          ok = (b != 16'h0000);
          if (ok) begin
            st_next.w[`DEFAULT_REG] = 16'($signed(a) / $signed(b));
            st_next.w[`REM_REG] = 16'($signed(a) % $signed(b));
          end
        end
        default: ok = 1'b0;
      endcase
      if (I_CMD.op <= OP_ASR && I_CMD.op != OP_NOP) begin
        if (to_file) begin
          st_next.file_we = 1'b1;
          st_next.file_wdata = res;
        end else begin
          st_next.w[di] = res;
        end
      end
      if (!ok) begin
        // an illegal operand set leaves every register untouched
        st_next = keep;
        st_next.err = 1'b1;
      end
    end
    // software access comes after the datapath and wins a clash
    if (I_WR) begin
      if (I_ADDR <= `ADDR_W_LAST) begin
        st_next.w[I_ADDR[3:0]] = I_WDATA;
      end else if (I_ADDR == `ADDR_STATUS) begin
        st_next.fl = I_WDATA[8:0];
      end
    end
    if (I_RD) begin
      unique case (I_ADDR)
        `ADDR_STATUS: st_next.rdata = {7'h00, st_reg.fl};
        `ADDR_ACCA_L: st_next.rdata = st_reg.acc_a[15:0];
        `ADDR_ACCA_H: st_next.rdata = st_reg.acc_a[31:16];
        `ADDR_ACCA_U: st_next.rdata = {8'h00, st_reg.acc_a[39:32]};
        `ADDR_ACCB_L: st_next.rdata = st_reg.acc_b[15:0];
        `ADDR_ACCB_H: st_next.rdata = st_reg.acc_b[31:16];
        `ADDR_ACCB_U: st_next.rdata = {8'h00, st_reg.acc_b[39:32]};
        default: begin
          st_next.rdata = (I_ADDR <= `ADDR_W_LAST) ?
                          st_reg.w[I_ADDR[3:0]] : 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_reg <= `STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign O_RDATA      = st_reg.rdata;
  assign O_FILE_WDATA = st_reg.file_wdata;
  assign O_FILE_WE    = st_reg.file_we;
  assign O_X_ADDR     = st_reg.x_addr;
  assign O_X_RE       = st_reg.x_re;
  assign O_Y_ADDR     = st_reg.y_addr;
  assign O_Y_RE       = st_reg.y_re;
  assign O_FLAGS      = st_reg.fl;
  assign O_ERROR      = st_reg.err;

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);

  sequence quiet_cmd(op_type o);
    I_CMD.valid && I_CMD.op == o && !I_WR;
  endsequence

  sqr_pair_a: assert property (
    quiet_cmd(OP_SQR) ##0 !is_mac(I_CMD.src) |=> O_ERROR)
    else $error("square accepted a register outside four to seven");

  mpy_pair_a: assert property (
    quiet_cmd(OP_MPY) ##0 (I_CMD.base >= I_CMD.src) |=> O_ERROR)
    else $error("multiply accepted an illegal register pair");

  xptr_step_a: assert property (
    quiet_cmd(OP_MPY) ##0 (I_CMD.x_mode == PF_INC6 && !I_CMD.x_alt)
    |=> O_ERROR || st_reg.w[8] == $past(st_reg.w[8]) + 16'h0006)
    else $error("x pointer not advanced by six");

  xfetch_dst_a: assert property (
    quiet_cmd(OP_MPY) ##0 (I_CMD.x_mode == PF_PLAIN)
    |=> O_ERROR || (O_X_RE &&
        st_reg.w[{2'b01, $past(I_CMD.x_dst)}] == $past(I_CMD.x_rdata)))
    else $error("x fetched word not in its destination");

  def_sum_a: assert property (
    quiet_cmd(OP_ADD_WITH_CARRY) ##0 (I_CMD.form == FM_FILE_DEF) |=>
    st_reg.w[0] == 16'($past(I_CMD.file_rdata) + $past(st_reg.w[0])
                       + {15'h0000, $past(st_reg.fl.c)}))
    else $error("carry add into default register wrong");

  asr_sign_a: assert property (
    quiet_cmd(OP_ASR) ##0 (I_CMD.form == FM_FILE) |=>
    O_FILE_WE && O_FILE_WDATA[15:14] == {2{$past(I_CMD.file_rdata[15])}}
    && O_FLAGS.c == $past(I_CMD.file_rdata[0]) && !O_FLAGS.ov)
    else $error("one bit shift lost the sign or carry");

  nz_only_a: assert property (
    quiet_cmd(OP_ASR) ##0 (I_CMD.form == FM_SH_REG) |=>
    $stable(O_FLAGS.c) && $stable(O_FLAGS.ov) && $stable(O_FLAGS.dc))
    else $error("count shift touched carry or range flags");

  and_flags_a: assert property (
    quiet_cmd(OP_AND) |=> $stable(O_FLAGS.c) && $stable(O_FLAGS.dc))
    else $error("and changed carry flags");

  acc_only_a: assert property (
    quiet_cmd(OP_ACC_ADD) ##0 (I_CMD.form <= FM_SH_LIT)
    |=> $stable(O_FLAGS[4:0]) && !O_ERROR)
    else $error("accumulator add changed core flags");

  lit_range_a: assert property (
    (quiet_cmd(OP_ADD) or quiet_cmd(OP_ADD_WITH_CARRY)) ##0
    (I_CMD.form == FM_MEDIUM_LITERAL && I_CMD.byte_mode
    && I_CMD.lit > 10'h0ff) |=> O_ERROR && $stable(st_reg.w))
    else $error("byte literal above range accepted");

endmodule

// *** testbench/tb_dsc_alu.sv ***
// self-checking bench of the operand select and arithmetic datapath
`timescale 1ns/1ns
module tb_dsc_alu;
  import dsc_alu_pkg::*;
  logic        I_CLOCK;
  logic        I_RSTN;
  cmd_type     I_CMD;
  logic [4:0]  I_ADDR;
  logic [15:0] I_WDATA;
  logic        I_WR;
  logic        I_RD;
  logic [15:0] O_RDATA;
  logic [15:0] O_FILE_WDATA;
  logic        O_FILE_WE;
  logic [15:0] O_X_ADDR;
  logic        O_X_RE;
  logic [15:0] O_Y_ADDR;
  logic        O_Y_RE;
  flags_type   O_FLAGS;
  logic        O_ERROR;
  int          failures;
  int          total_checks;
  int          i;
  int          j;
  logic [15:0] p;
  cmd_type     c;
  int          dl [8] = '{0, 0, 2, 4, 6, -2, -4, -6};

  dsc_alu #(.NUM_REGS(16)) DUT (
    .I_CLOCK     (I_CLOCK),
    .I_RSTN      (I_RSTN),
    .I_CMD       (I_CMD),
    .I_ADDR      (I_ADDR),
    .I_WDATA     (I_WDATA),
    .I_WR        (I_WR),
    .I_RD        (I_RD),
    .O_RDATA     (O_RDATA),
    .O_FILE_WDATA(O_FILE_WDATA),
    .O_FILE_WE   (O_FILE_WE),
    .O_X_ADDR    (O_X_ADDR),
    .O_X_RE      (O_X_RE),
    .O_Y_ADDR    (O_Y_ADDR),
    .O_Y_RE      (O_Y_RE),
    .O_FLAGS     (O_FLAGS),
    .O_ERROR     (O_ERROR)
  );

  initial begin
    I_CLOCK = 1'b0;
    forever #2 I_CLOCK = ~I_CLOCK;
  end

  task automatic end_sim();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got,
               exp);
    end
  endtask

  // one idle cycle between accesses keeps each strobe a single pulse
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge I_CLOCK);
    I_WR    <= 1'b1;
    I_ADDR  <= a;
    I_WDATA <= d;
    @(posedge I_CLOCK);
    I_WR <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge I_CLOCK);
    I_RD   <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLOCK);
    I_RD <= 1'b0;
    #1;
    chk(O_RDATA, e, "read data");
    @(posedge I_CLOCK);
    #1;
    chk(O_RDATA, 16'h0000, "read data after its cycle");
  endtask

  task automatic run(input cmd_type k);
    @(posedge I_CLOCK);
    I_CMD <= k;
    @(posedge I_CLOCK);
    I_CMD <= '0;
    #1;
  endtask

  task automatic err(input logic e);
    chk(16'(O_ERROR), 16'(e), "refusal pulse");
  endtask

  function automatic cmd_type mk(op_type o, form_type f, logic [3:0] s,
                                 logic [3:0] b, logic [3:0] d,
                                 logic [9:0] l, logic [15:0] fr);
    cmd_type k;
    k = '0;
    k.valid = 1'b1;
    k.op = o;
    k.form = f;
    k.src = s;
    k.base = b;
    k.dst = d;
    k.lit = l;
    k.file_rdata = fr;
    return k;
  endfunction

  // generous bound, the sequence needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge I_CLOCK);
    failures++;
    end_sim();
  end

  initial begin
    I_RSTN = 1'b0;
    I_CMD = '0;
    I_ADDR = '0;
    I_WDATA = '0;
    I_WR = 1'b0;
    I_RD = 1'b0;
    failures = 0;
    total_checks = 0;
    repeat (10) @(posedge I_CLOCK);
    I_RSTN <= 1'b1;
    for (i = 0; i < 17; i++) rd(5'(i), 16'h0000);
    rd(5'h1f, 16'h0000);
    for (i = 0; i < 16; i++) wr(5'(i), 16'(i * 16'h1111));
    for (i = 0; i < 16; i++) rd(5'(i), 16'(i * 16'h1111));
    // carry add into file: zero result must not set the sticky zero
    wr(5'h00, 16'h0001);
    wr(5'h10, 16'h0001);
    run(mk(OP_ADD_WITH_CARRY, FM_FILE, 0, 0, 0, 0, 16'hfffe));
    chk(O_FILE_WDATA, 16'h0000, "file sum");
    chk(16'(O_FILE_WE), 16'h0001, "file strobe");
    chk(16'(O_FLAGS), 16'h0003, "flag pins");
    rd(5'h10, 16'h0003);
    wr(5'h10, 16'h0011);
    run(mk(OP_ADD_WITH_CARRY, FM_FILE, 0, 0, 0, 0, 16'hfffe));
    rd(5'h10, 16'h0013);
    wr(5'h00, 16'h0003);
    wr(5'h10, 16'h0001);
    run(mk(OP_ADD_WITH_CARRY, FM_FILE_DEF, 0, 0, 0, 0, 16'h0005));
    rd(5'h00, 16'h0009);
    rd(5'h10, 16'h0000);
    wr(5'h03, 16'h0010);
    wr(5'h10, 16'h0001);
    run(mk(OP_ADD_WITH_CARRY, FM_MEDIUM_LITERAL, 0, 0, 3, 10'h3ff, 0));
    rd(5'h03, 16'h0410);
    rd(5'h10, 16'h0002);
    c = mk(OP_ADD_WITH_CARRY, FM_MEDIUM_LITERAL, 0, 0, 3, 10'h100, 0);
    c.byte_mode = 1'b1;
    run(c);
    err(1'b1);
    rd(5'h03, 16'h0410);
    c.lit = 10'h0ff;
    run(c);
    err(1'b0);
    rd(5'h03, 16'h050f);
    // only the low five literal bits may reach the adder
    wr(5'h02, 16'h7fff);
    wr(5'h10, 16'h0001);
    run(mk(OP_ADD_WITH_CARRY, FM_SHORT_LITERAL, 0, 2, 5, 10'h3ff, 0));
    rd(5'h05, 16'h801f);
    rd(5'h10, 16'h000e);
    wr(5'h10, 16'h0001);
    run(mk(OP_ADD, FM_REG3, 1, 1, 6, 0, 0));
    rd(5'h06, 16'h2222);
    rd(5'h10, 16'h0000);
    wr(5'h08, 16'hffff);
    run(mk(OP_ADD, FM_SHORT_LITERAL, 0, 8, 9, 10'h001, 0));
    rd(5'h09, 16'h0000);
    rd(5'h10, 16'h0013);
    wr(5'h10, 16'h0009);
    run(mk(OP_AND, FM_REG3, 5, 8, 10, 0, 0));
    rd(5'h0a, 16'h801f);
    rd(5'h10, 16'h000d);
    wr(5'h10, 16'h0002);
    run(mk(OP_ASR, FM_FILE, 0, 0, 0, 0, 16'h8003));
    chk(O_FILE_WDATA, 16'hc001, "shifted file");
    rd(5'h10, 16'h0007);
    run(mk(OP_ASR, FM_FILE_DEF, 0, 0, 0, 0, 16'h0002));
    rd(5'h00, 16'h0001);
    rd(5'h10, 16'h0002);
    run(mk(OP_ASR, FM_REG3, 5, 0, 11, 0, 0));
    rd(5'h0b, 16'hc00f);
    rd(5'h10, 16'h0007);
    wr(5'h10, 16'h0001);
    run(mk(OP_ASR, FM_SH_LIT, 0, 5, 12, 10'h004, 0));
    rd(5'h0c, 16'hf801);
    rd(5'h10, 16'h0005);
    // count register bits above 4:0 must be ignored
    wr(5'h0d, 16'h0021);
    run(mk(OP_ASR, FM_SH_REG, 13, 6, 14, 0, 0));
    rd(5'h0e, 16'h1111);
    rd(5'h10, 16'h0001);
    for (i = 0; i < 16; i++) begin
      run(mk(OP_SQR, FM_FILE, 4'(i), 4'(i), 0, 0, 0));
      err(i < 4 || i > 7);
    end
    for (i = 3; i < 9; i++) begin
      for (j = 3; j < 9; j++) begin
        run(mk(OP_MPY, FM_FILE, 4'(j), 4'(i), 0, 0, 0));
        err(!(i >= 4 && i < j && j <= 7));
        chk(16'(O_X_RE), 16'h0000, "no prefetch");
      end
    end
    wr(5'h08, 16'h1000);
    wr(5'h0a, 16'h2000);
    p = 16'h1000;
    for (i = 1; i < 8; i++) begin
      c = mk(OP_MPY, FM_FILE, 5, 4, 0, 0, 0);
      c.x_mode = pf_type'(i);
      c.y_mode = pf_type'(i);
      c.x_dst = 2'h2;
      c.y_dst = 2'h3;
      c.x_rdata = 16'(i);
      c.y_rdata = ~16'(i);
      run(c);
      chk(O_X_ADDR, p, "x address");
      chk(O_Y_ADDR, p + 16'h1000, "y address");
      chk(16'(O_X_RE & O_Y_RE), 16'h0001, "prefetch pulses");
      rd(5'h06, 16'(i));
      rd(5'h07, ~16'(i));
      p = p + 16'(dl[i]);
      rd(5'h08, p);
      rd(5'h0a, p + 16'h1000);
    end
    wr(5'h09, 16'h0100);
    wr(5'h0b, 16'h0300);
    wr(5'h0c, 16'h0020);
    c = mk(OP_MPY, FM_FILE, 5, 4, 0, 0, 0);
    c.x_mode = PF_INDEX;
    c.y_mode = PF_INDEX;
    c.x_alt = 1'b1;
    c.y_alt = 1'b1;
    run(c);
    chk(O_X_ADDR, 16'h0120, "x indexed");
    chk(O_Y_ADDR, 16'h0320, "y indexed");
    // signed product of w4 and w5 sign extended into accumulator a
    rd(5'h11, 16'h443c);
    rd(5'h12, 16'hdde6);
    rd(5'h13, 16'h00ff);
    c.x_alt = 1'b0;
    run(c);
    err(1'b1);
    c.x_alt = 1'b1;
    c.y_alt = 1'b0;
    run(c);
    err(1'b1);
    // same register on both sides so operand order cannot matter
    wr(5'h02, 16'h0007);
    run(mk(OP_DIV, FM_FILE, 2, 2, 0, 0, 0));
    rd(5'h00, 16'h0001);
    rd(5'h01, 16'h0000);
    wr(5'h03, 16'h0000);
    run(mk(OP_DIV, FM_FILE, 3, 3, 0, 0, 0));
    err(1'b1);
    rd(5'h00, 16'h0001);
    wr(5'h10, 16'h001f);
    c = mk(OP_ACC_ADD, FM_FILE, 14, 0, 0, 0, 0);
    c.acc_b = 1'b1;
    run(c);
    rd(5'h15, 16'h1111);
    rd(5'h14, 16'h0000);
    rd(5'h16, 16'h0000);
    rd(5'h10, 16'h001f);
    wr(5'h15, 16'hbeef);
    rd(5'h15, 16'h1111);
    // negative shift literal shifts left, pushing bits above bit 31
    c.lit = 10'h008;
    run(c);
    rd(5'h16, 16'h0011);
    rd(5'h10, 16'h005f);
    // a second large add overflows 40 bits and clamps positive
    wr(5'h0f, 16'h7fff);
    c.src = 4'hf;
    run(c);
    rd(5'h14, 16'hffff);
    rd(5'h16, 16'h007f);
    rd(5'h10, 16'h015f);
    end_sim();
  end
endmodule
